// >>> rtl/alarm_status_device.sv
module alarm_status_device #(
   parameter int GPIO_W = 4,
   parameter logic [3:0] REVISION = 4'h3 // Arbitrary value
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link to the controller
   status_link.device_end link,
   // Range monitor events, order onl onh opl oph inl inh ipl iph
   input wire logic [7:0] alarm_event,
   // Conversion core
   input wire logic conv_done,
   output logic conv_start,
   output logic core_reset,
   output logic [7:0] gain_select,
   // Clock source state
   output logic osc_internal,
   output logic osc_external,
   output logic osc_halted,
   // General-purpose pins
   input wire logic [GPIO_W-1:0] gpio_i,
   output logic [GPIO_W-1:0] gpio_o,
   output logic [GPIO_W-1:0] gpio_oe
);
   import status_link_pkg::*;

   logic [7:0] alarm_q;
   logic [7:0] alarm_d;
   logic [1:0] rsvd_q;
   logic lock_q;
   logic check_err_q;
   logic check_err_d;
   logic [7:0] gain_q;
   logic [7:0] conv_ctrl_q;
   logic [GPIO_W-1:0] gpio_dir_q;
   logic [GPIO_W-1:0] gpio_level_q;
   logic busy_q;
   logic busy_d;
   logic ready_q;
   logic ready_d;
   logic start_pin_q;
   logic conv_start_q;
   logic core_reset_q;
   logic rsp_valid_q;
   logic [7:0] rsp_data_q;
   logic srdy_q;
   logic ready_n_q;
   logic clk_pin_q;
   logic [3:0] quiet_q;
   logic [3:0] quiet_d;
   logic osc_int_q;
   logic osc_ext_q;
   logic osc_halt_q;

   // Command decode
   wire selected = ~link.first_chip_select_n | ~link.second_chip_select_n;
   wire [7:0] expect_check = check_byte(link.cmd_op, link.cmd_addr,
      link.cmd_data);
   wire check_ok = link.second_chip_select_n |
      (link.cmd_check == expect_check);
   wire cmd_take = link.cmd_valid & selected;
   wire cmd_ok = cmd_take & check_ok;
   wire check_fail = cmd_take & ~check_ok;
   wire [7:0] addr = link.cmd_addr;
   wire in_lock_range = (addr >= LOCK_LO) && (addr <= LOCK_HI);
   wire wr = cmd_ok && (link.cmd_op == OP_WRITE) &&
      !(lock_q && in_lock_range);
   wire rd = cmd_ok && (link.cmd_op == OP_READ);
   wire reset_cmd = cmd_ok && (link.cmd_op == OP_RESET);
   wire lock_cmd = cmd_ok && (link.cmd_op == OP_LOCK);
   wire unlock_cmd = cmd_ok && (link.cmd_op == OP_UNLOCK);
   wire start_cmd = cmd_ok && (link.cmd_op == OP_START);
   wire wr_lock_checksum_revision_status = wr && (addr == ADDR_LOCK_STATUS);
   wire rd_alarm = rd && (addr == ADDR_ALARMS);
   wire rst = ~aresetn | ~link.reset_pin_n | reset_cmd;

   // Alarms: events win over the clearing read
   assign alarm_d = (alarm_q & ~{8{rd_alarm}}) | alarm_event;
   assign check_err_d = (check_err_q &
      ~(wr_lock_checksum_revision_status & ~link.cmd_data[CHECK_ERR_BIT])) | check_fail;

   // Conversion start
   wire free_run = link.start_pin & conv_ctrl_q[CONT_BIT];
   wire start_rise = link.start_pin & ~start_pin_q;
   wire start_go = ~osc_halt_q & ~busy_q &
      (start_cmd | start_rise | free_run);
   assign busy_d = (busy_q & ~conv_done) | start_go;
   assign ready_d = (ready_q & ~start_go) | conv_done;

   // Clock source detection
   wire clk_toggled = link.clock_source_pin ^ clk_pin_q;
   assign quiet_d = clk_toggled ? 4'h0 :
      (quiet_q == CLK_QUIET_CYC) ? CLK_QUIET_CYC : quiet_q + 4'h1;
   wire ext_seen = quiet_d != CLK_QUIET_CYC;

   // Read data selection
   wire [7:0] lock_checksum_revision_status = {rsvd_q, lock_q, check_err_q, REVISION};
   wire [7:0] first_status = {6'h00, busy_q, ready_q};
   wire [7:0] gpio_dir_rd = 8'(gpio_dir_q);
   wire [7:0] gpio_in_rd = 8'(gpio_i);
   wire [7:0] read_value =
      (addr == ADDR_ALARMS) ? alarm_q :
      (addr == ADDR_LOCK_STATUS) ? lock_checksum_revision_status :
      (addr == ADDR_FIRST_STATUS) ? first_status :
      (addr == ADDR_CONV_CTRL) ? conv_ctrl_q :
      (addr == ADDR_GPIO_DIR) ? gpio_dir_rd :
      (addr == ADDR_GPIO_LEVEL) ? gpio_in_rd :
      (addr == ADDR_GAIN_SELECT) ? gain_q : 8'h00;

   // Register bank
   always_ff @(posedge aclk)
   begin
      if (rst)
      begin
         alarm_q <= ALARMS_RST;
         rsvd_q <= 2'h0;
         lock_q <= 1'b0;
         check_err_q <= 1'b0;
         gain_q <= GAIN_SELECT_RST;
         conv_ctrl_q <= CONV_CTRL_RST;
         gpio_dir_q <= '1;
         gpio_level_q <= '0;
      end
      else
      begin
         alarm_q <= alarm_d;
         check_err_q <= check_err_d;
         if (lock_cmd)
            lock_q <= 1'b1;
         else if (unlock_cmd)
            lock_q <= 1'b0;
         if (wr_lock_checksum_revision_status)
            rsvd_q <= link.cmd_data[7:RSVD_LSB];
         if (wr && addr == ADDR_GAIN_SELECT)
            gain_q <= link.cmd_data;
         if (wr && addr == ADDR_CONV_CTRL)
            conv_ctrl_q <= link.cmd_data;
         if (wr && addr == ADDR_GPIO_DIR)
            gpio_dir_q <= link.cmd_data[GPIO_W-1:0];
         if (wr && addr == ADDR_GPIO_LEVEL)
            gpio_level_q <= link.cmd_data[GPIO_W-1:0];
      end
   end

   // Conversion and answer path
   always_ff @(posedge aclk)
   begin
      if (rst)
      begin
         busy_q <= 1'b0;
         ready_q <= 1'b0;
         start_pin_q <= 1'b0;
         conv_start_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= 8'h00;
         srdy_q <= 1'b1;
         ready_n_q <= 1'b1;
      end
      else
      begin
         busy_q <= busy_d;
         ready_q <= ready_d;
         start_pin_q <= link.start_pin;
         conv_start_q <= start_go;
         rsp_valid_q <= rd;
         rsp_data_q <= read_value;
         srdy_q <= link.first_chip_select_n | ~ready_d;
         ready_n_q <= ~ready_d;
      end
   end

   // Reset indication, held for every cycle of any reset source
   always_ff @(posedge aclk)
   begin
      core_reset_q <= rst;
   end

   // Clock source state survives the reset pin and command
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clk_pin_q <= 1'b0;
         quiet_q <= CLK_QUIET_CYC;
         osc_int_q <= 1'b1;
         osc_ext_q <= 1'b0;
         osc_halt_q <= 1'b0;
      end
      else
      begin
         clk_pin_q <= link.clock_source_pin;
         quiet_q <= quiet_d;
         osc_ext_q <= ext_seen;
         osc_halt_q <= ~ext_seen & link.clock_source_pin;
         osc_int_q <= ~ext_seen & ~link.clock_source_pin;
      end
   end

   assign link.rsp_valid = rsp_valid_q;
   assign link.rsp_data = rsp_data_q;
   assign link.serial_out_ready_pin = srdy_q;
   assign link.conversion_ready_n = ready_n_q;
   assign conv_start = conv_start_q;
   assign core_reset = core_reset_q;
   assign gain_select = gain_q;
   assign osc_internal = osc_int_q;
   assign osc_external = osc_ext_q;
   assign osc_halted = osc_halt_q;
   assign gpio_o = gpio_level_q;
   assign gpio_oe = gpio_dir_q;
endmodule : alarm_status_device

// >>> rtl/status_link_host.sv
module status_link_host
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link to the device
   status_link.host_end link,
   // AXI4-Lite write
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Interrupt
   output logic irq
);
   import status_link_pkg::*;

   typedef enum {ST_IDLE, ST_SEND, ST_WAIT} host_state_t;

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      for (int i = 0; i < 4; i++)
         merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
   endfunction : merge

   host_state_t state_q;
   logic have_aw_q, have_w_q, awready_q, wready_q, bvalid_q;
   logic arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q, rdata_q;
   logic [3:0] wstrb_q;
   logic [CTRL_W-1:0] ctrl_q;
   logic [1:0] irq_q, mask_q;
   logic irq_out_q;
   logic [7:0] last_rd_q;
   logic srdy_q;
   logic [3:0] div_q;
   logic clk_ext_q, clk_pin_q, start_q, reset_n_q, first_n_q, second_n_q;
   logic cmd_valid_q;
   logic [2:0] op_q;
   logic [7:0] addr_q, data_q, check_q;

   // Write channel handshakes
   wire aw_fire = awvalid & awready_q;
   wire w_fire = wvalid & wready_q;
   wire do_write = have_aw_q & have_w_q & ~bvalid_q;
   wire aw_next = (have_aw_q | aw_fire) & ~do_write;
   wire w_next = (have_w_q | w_fire) & ~do_write;
   wire bvalid_next = do_write | (bvalid_q & ~bready);
   wire w_known = waddr_q == REG_CTRL || waddr_q == REG_CMD ||
      waddr_q == REG_STATUS || waddr_q == REG_IRQ_STATUS ||
      waddr_q == REG_IRQ_MASK;
   wire [31:0] ctrl_new = merge(32'(ctrl_q), wdata_q, wstrb_q);
   wire [31:0] mask_new = merge(32'(mask_q), wdata_q, wstrb_q);
   wire [31:0] cmd_new = merge(32'h0, wdata_q, wstrb_q);
   wire kick = do_write && waddr_q == REG_CMD && (|wstrb_q) &&
      state_q == ST_IDLE;

   // Read channel handshakes
   wire ar_fire = arvalid & arready_q;
   wire rvalid_next = ar_fire | (rvalid_q & ~rready);
   wire r_known = araddr == REG_CTRL || araddr == REG_CMD ||
      araddr == REG_STATUS || araddr == REG_IRQ_STATUS ||
      araddr == REG_IRQ_MASK;
   wire busy = state_q != ST_IDLE;
   wire [31:0] rd_value =
      (araddr == REG_CTRL) ? 32'(ctrl_q) :
      (araddr == REG_STATUS) ? {16'h0, last_rd_q, 6'h0, ~srdy_q, busy} :
      (araddr == REG_IRQ_STATUS) ? 32'(irq_q) :
      (araddr == REG_IRQ_MASK) ? 32'(mask_q) : 32'h0;
   wire irq_clear = ar_fire && araddr == REG_IRQ_STATUS;

   // Events
   wire done_evt = (state_q == ST_SEND && op_q != OP_READ) ||
      (state_q == ST_WAIT && (link.rsp_valid | ~reset_n_q));
   wire ready_evt = ~link.serial_out_ready_pin & srdy_q;
   wire [1:0] evt = {ready_evt, done_evt};
   wire [1:0] irq_next = (irq_q & ~({2{irq_clear}} & irq_q)) | evt;
   wire [1:0] clk_mode = ctrl_q[CTRL_CLK_LSB +: 2];

   // Register bus slave
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         have_aw_q <= 1'b0;
         have_w_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0;
         waddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         ctrl_q <= '0;
         mask_q <= 2'h0;
         irq_q <= 2'h0;
         irq_out_q <= 1'b0;
      end
      else
      begin
         have_aw_q <= aw_next;
         have_w_q <= w_next;
         awready_q <= ~aw_next;
         wready_q <= ~w_next;
         bvalid_q <= bvalid_next;
         arready_q <= ~rvalid_next;
         rvalid_q <= rvalid_next;
         irq_q <= irq_next;
         irq_out_q <= |(irq_next & mask_q);
         if (aw_fire)
            waddr_q <= awaddr;
         if (w_fire)
         begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (do_write)
         begin
            bresp_q <= w_known ? RESP_OKAY : RESP_SLVERR;
            if (waddr_q == REG_CTRL)
               ctrl_q <= ctrl_new[CTRL_W-1:0];
            if (waddr_q == REG_IRQ_MASK)
               mask_q <= mask_new[1:0];
         end
         if (ar_fire)
         begin
            rdata_q <= rd_value;
            rresp_q <= r_known ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   // Link pins and command sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_q <= ST_IDLE;
         cmd_valid_q <= 1'b0;
         op_q <= 3'h0;
         addr_q <= 8'h00;
         data_q <= 8'h00;
         check_q <= 8'h00;
         last_rd_q <= 8'h00;
         srdy_q <= 1'b1;
         div_q <= 4'h0;
         clk_ext_q <= 1'b0;
         clk_pin_q <= 1'b0;
         start_q <= 1'b0;
         reset_n_q <= 1'b1;
         first_n_q <= 1'b1;
         second_n_q <= 1'b1;
      end
      else
      begin
         srdy_q <= link.serial_out_ready_pin;
         start_q <= ctrl_q[CTRL_START];
         reset_n_q <= ~ctrl_q[CTRL_RESET];
         first_n_q <= ~ctrl_q[CTRL_FIRST];
         second_n_q <= ~ctrl_q[CTRL_SECOND];
         div_q <= (div_q == CLK_HALF_CYC - 4'h1) ? 4'h0 : div_q + 4'h1;
         if (div_q == CLK_HALF_CYC - 4'h1)
            clk_ext_q <= ~clk_ext_q;
         clk_pin_q <= (clk_mode == CLK_EXTERNAL) ? clk_ext_q :
            (clk_mode == CLK_HALT);
         case (state_q)
            ST_IDLE:
            begin
               if (kick)
               begin
                  op_q <= cmd_new[CMD_OP_LSB +: 3];
                  addr_q <= cmd_new[7:0];
                  data_q <= cmd_new[CMD_DATA_LSB +: 8];
                  check_q <= check_byte(cmd_new[CMD_OP_LSB +: 3],
                     cmd_new[7:0], cmd_new[CMD_DATA_LSB +: 8]) ^
                     {7'h00, cmd_new[CMD_BAD_CHECK]};
                  cmd_valid_q <= 1'b1;
                  state_q <= ST_SEND;
               end
            end
            ST_SEND:
            begin
               cmd_valid_q <= 1'b0;
               state_q <= (op_q == OP_READ) ? ST_WAIT : ST_IDLE;
            end
            ST_WAIT:
            begin
               if (link.rsp_valid)
                  last_rd_q <= link.rsp_data;
               if (link.rsp_valid | ~reset_n_q)
                  state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // Every device input is driven to a level from reset on
   assign link.clock_source_pin = clk_pin_q;
   assign link.start_pin = start_q;
   assign link.reset_pin_n = reset_n_q;
   assign link.first_chip_select_n = first_n_q;
   assign link.second_chip_select_n = second_n_q;
   assign link.cmd_valid = cmd_valid_q;
   assign link.cmd_op = op_q;
   assign link.cmd_addr = addr_q;
   assign link.cmd_data = data_q;
   assign link.cmd_check = check_q;
   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;
   assign irq = irq_out_q;
endmodule : status_link_host

// >>> shared/status_link.sv
interface status_link;
   import status_link_pkg::*;
   logic clock_source_pin;
   logic start_pin;
   logic reset_pin_n;
   logic first_chip_select_n;
   logic second_chip_select_n;
   logic cmd_valid;
   logic [2:0] cmd_op;
   logic [7:0] cmd_addr;
   logic [7:0] cmd_data;
   logic [7:0] cmd_check;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic serial_out_ready_pin;
   logic conversion_ready_n;

   modport device_end
   (
      input clock_source_pin, start_pin, reset_pin_n, first_chip_select_n,
      input second_chip_select_n, cmd_valid, cmd_op, cmd_addr, cmd_data,
      input cmd_check,
      output rsp_valid, rsp_data, serial_out_ready_pin, conversion_ready_n
   );

   modport host_end
   (
      output clock_source_pin, start_pin, reset_pin_n, first_chip_select_n,
      output second_chip_select_n, cmd_valid, cmd_op, cmd_addr, cmd_data,
      output cmd_check,
      input rsp_valid, rsp_data, serial_out_ready_pin, conversion_ready_n
   );
endinterface : status_link

// >>> shared/status_link_pkg.sv
package status_link_pkg;
   // Link field widths
   localparam int LINK_AW = 8;
   localparam int LINK_DW = 8;

   // Link commands
   typedef enum logic [2:0]
   {
      OP_READ,
      OP_WRITE,
      OP_START,
      OP_RESET,
      OP_LOCK,
      OP_UNLOCK
   } link_op_t;

   // Device register map
   localparam logic [7:0] ADDR_FIRST_STATUS = 8'h01;
   localparam logic [7:0] ADDR_CONV_CTRL = 8'h02;
   localparam logic [7:0] ADDR_GPIO_DIR = 8'h03;
   localparam logic [7:0] ADDR_GPIO_LEVEL = 8'h04;
   localparam logic [7:0] ADDR_GAIN_SELECT = 8'h10;
   localparam logic [7:0] ADDR_ALARMS = 8'h11;
   localparam logic [7:0] ADDR_LOCK_STATUS = 8'h12;
   localparam logic [7:0] LOCK_LO = 8'h10;
   localparam logic [7:0] LOCK_HI = 8'h12;

   // Device field positions and reset values
   localparam int LOCK_BIT = 5;
   localparam int CHECK_ERR_BIT = 4;
   localparam int RSVD_LSB = 6;
   localparam int READY_BIT = 0;
   localparam int BUSY_BIT = 1;
   localparam int CONT_BIT = 0;
   localparam logic [7:0] GAIN_SELECT_RST = 8'h50;
   localparam logic [7:0] CONV_CTRL_RST = 8'h00;
   localparam logic [7:0] ALARMS_RST = 8'h00;
   localparam logic [7:0] CHECK_SEED = 8'ha5;
   localparam logic [3:0] CLK_QUIET_CYC = 4'hf;

   // Controller register map, one 32-bit word each
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h0c;
   localparam logic [7:0] REG_IRQ_MASK = 8'h10;
   localparam int CTRL_W = 7;
   localparam int CTRL_CLK_LSB = 0;
   localparam int CTRL_START = 2;
   localparam int CTRL_RESET = 3;
   localparam int CTRL_FIRST = 4;
   localparam int CTRL_SECOND = 5;
   localparam int CTRL_CONT = 6;
   localparam int CMD_DATA_LSB = 8;
   localparam int CMD_OP_LSB = 16;
   localparam int CMD_BAD_CHECK = 19;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_READY = 1;
   localparam logic [3:0] CLK_HALF_CYC = 4'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0]
   {
      CLK_INTERNAL,
      CLK_HALT,
      CLK_EXTERNAL
   } clk_mode_t;

   // Check byte carried with every command
   function automatic logic [7:0] check_byte(input logic [2:0] op,
      input logic [7:0] addr, input logic [7:0] data);
      check_byte = {5'h00, op} ^ addr ^ data ^ CHECK_SEED;
   endfunction : check_byte
endpackage : status_link_pkg

// >>> testbench/status_link_monitor.sv
module status_link_monitor
#(
   parameter logic [3:0] REVISION = 4'h3
)
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link signals
   input wire logic reset_pin_n,
   input wire logic first_chip_select_n,
   input wire logic second_chip_select_n,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_op,
   input wire logic [7:0] cmd_addr,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_data,
   input wire logic serial_out_ready_pin,
   input wire logic conversion_ready_n
);
   timeunit 1ns;
   timeprecision 1ps;
   import status_link_pkg::*;
   wire rd_go;
   assign rd_go = cmd_valid && cmd_op == OP_READ && !first_chip_select_n
      && second_chip_select_n && reset_pin_n;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   rsp_after_read_a: assert property (rd_go |=> rsp_valid)
      else $error("read answer missing");
   rsp_cause_a: assert property (
      rsp_valid |-> $past(cmd_valid) && $past(cmd_op) == OP_READ)
      else $error("answer without read");
   rsp_single_a: assert property (rsp_valid |=> !rsp_valid)
      else $error("answer longer than one cycle");
   rev_field_a: assert property (
      rd_go && cmd_addr == ADDR_LOCK_STATUS
      |=> rsp_data[3:0] == REVISION && rsp_data[7:6] == 2'h0)
      else $error("status byte fields wrong");
   ready_select_a: assert property (
      !serial_out_ready_pin |-> $past(!first_chip_select_n))
      else $error("ready shown without select");
   pin_reset_a: assert property (
      !reset_pin_n |=> !rsp_valid && serial_out_ready_pin
      && conversion_ready_n)
      else $error("reset pin ignored");
   cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
      else $error("command held too long");
   read_gap_a: assert property (
      cmd_valid && cmd_op == OP_READ |=> !cmd_valid [*2])
      else $error("read spacing too short");
endmodule : status_link_monitor

// >>> testbench/test_alarm_and_status_registers.sv
module test_alarm_and_status_registers;
   timeunit 1ns;
   timeprecision 1ps;
   import status_link_pkg::*;
   localparam logic [3:0] REV = 4'h9; // Arbitrary value
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, conv_done = 1'h0;
   logic [31:0] wdata = 32'h0, rdata, s;
   logic awready, wready, bvalid, arready, rvalid, irq, seen;
   logic [1:0] bresp, rresp, rsp;
   logic [7:0] alarm_event = 8'h00, gain_select, ev, alm, g, rd_b;
   logic [3:0] gpio_i = 4'h6, gpio_o, gpio_oe;
   logic conv_start, core_reset, osc_internal, osc_external, osc_halted;
   int n_mismatch = 0, tests_run = 0, cyc = 0, seed = 70746;
   status_link link_i ();
   alarm_status_device #(.GPIO_W(4), .REVISION(REV)) alarm_status_device_inst
   (
      .aclk, .aresetn, .link(link_i), .alarm_event, .conv_done, .conv_start,
      .core_reset, .gain_select, .osc_internal, .osc_external, .osc_halted,
      .gpio_i, .gpio_o, .gpio_oe
   );
   status_link_host status_link_host_inst
   (
      .aclk, .aresetn, .link(link_i), .awaddr, .awprot(3'h0), .awvalid,
      .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .irq
   );
   status_link_monitor #(.REVISION(REV)) mon
   (
      .aclk, .aresetn, .reset_pin_n(link_i.reset_pin_n),
      .first_chip_select_n(link_i.first_chip_select_n),
      .second_chip_select_n(link_i.second_chip_select_n),
      .cmd_valid(link_i.cmd_valid), .cmd_op(link_i.cmd_op),
      .cmd_addr(link_i.cmd_addr), .rsp_valid(link_i.rsp_valid),
      .rsp_data(link_i.rsp_data),
      .serial_out_ready_pin(link_i.serial_out_ready_pin),
      .conversion_ready_n(link_i.conversion_ready_n)
   );
   initial
   begin
      forever #12.5 aclk = ~aclk;
   end
   task automatic finish_test;
      $display("compares %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch = n_mismatch + 1;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      forever
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid)
         begin
            rsp = bresp;
            bready <= 1'h0;
            break;
         end
      end
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      forever
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         if (rvalid)
         begin
            d = rdata;
            rsp = rresp;
            rready <= 1'h0;
            break;
         end
      end
   endtask : axi_rd
   task automatic dev(input link_op_t op, input logic [7:0] a,
      input logic [7:0] d, input logic bad);
      axi_wr(REG_CMD, {12'h000, bad, op, d, a});
      s = 32'h1;
      while (s[0] !== 1'h0) axi_rd(REG_STATUS, s);
      rd_b = s[15:8];
   endtask : dev
   initial
   begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      chk(gpio_oe, 4'hf);
      chk(osc_internal, 1'h1);
      axi_rd(8'h20, s);
      chk(rsp, RESP_SLVERR);
      axi_wr(REG_CTRL, 32'h10);
      dev(OP_READ, ADDR_LOCK_STATUS, 8'h00, 1'h0);
      chk(rd_b, {4'h0, REV});
      dev(OP_READ, ADDR_ALARMS, 8'h00, 1'h0);
      for (int i = 0; i < 5; i++)
      begin
         ev = 8'($random(seed));
         alarm_event <= ev;
         @(posedge aclk);
         alarm_event <= 8'h00;
         alm = ev;
         dev(OP_READ, ADDR_ALARMS, 8'h00, 1'h0);
         chk(rd_b, alm);
      end
      dev(OP_READ, ADDR_ALARMS, 8'h00, 1'h0);
      chk(rd_b, 8'h00);
      $display("test alarms done");
      g = 8'($random(seed)) | 8'h01;
      dev(OP_LOCK, 8'h00, 8'h00, 1'h0);
      dev(OP_WRITE, ADDR_GAIN_SELECT, g, 1'h0);
      dev(OP_READ, ADDR_GAIN_SELECT, 8'h00, 1'h0);
      chk(rd_b, GAIN_SELECT_RST);
      dev(OP_READ, ADDR_LOCK_STATUS, 8'h00, 1'h0);
      chk(rd_b, {4'h2, REV});
      dev(OP_UNLOCK, 8'h00, 8'h00, 1'h0);
      dev(OP_WRITE, ADDR_GAIN_SELECT, g, 1'h0);
      dev(OP_READ, ADDR_GAIN_SELECT, 8'h00, 1'h0);
      chk(rd_b, g);
      chk(gain_select, g);
      $display("test lock done");
      axi_wr(REG_CTRL, 32'h20);
      dev(OP_WRITE, ADDR_CONV_CTRL, 8'h00, 1'h1);
      dev(OP_READ, ADDR_LOCK_STATUS, 8'h00, 1'h0);
      chk(rd_b, {4'h1, REV});
      dev(OP_WRITE, ADDR_LOCK_STATUS, 8'h00, 1'h0);
      dev(OP_READ, ADDR_LOCK_STATUS, 8'h00, 1'h0);
      chk(rd_b, {4'h0, REV});
      $display("test check error done");
      axi_wr(REG_CTRL, 32'h10);
      conv_done <= 1'h1;
      @(posedge aclk);
      conv_done <= 1'h0;
      repeat (4) @(posedge aclk);
      chk(irq, 1'h0);
      axi_wr(REG_IRQ_MASK, 32'h2);
      repeat (2) @(posedge aclk);
      chk(irq, 1'h1);
      axi_rd(REG_IRQ_STATUS, s);
      chk(s[IRQ_READY], 1'h1);
      repeat (2) @(posedge aclk);
      chk(irq, 1'h0);
      dev(OP_READ, ADDR_FIRST_STATUS, 8'h00, 1'h0);
      chk(rd_b[READY_BIT], 1'h1);
      axi_wr(REG_CTRL, 32'h00);
      repeat (3) @(posedge aclk);
      chk(link_i.serial_out_ready_pin, 1'h1);
      $display("test ready done");
      axi_wr(REG_CTRL, 32'h14);
      seen = 1'h0;
      repeat (10)
      begin
         @(posedge aclk);
         seen = seen | conv_start;
      end
      chk(seen, 1'h1);
      conv_done <= 1'h1;
      @(posedge aclk);
      conv_done <= 1'h0;
      axi_wr(REG_CTRL, 32'h18);
      repeat (2) @(posedge aclk);
      chk(core_reset, 1'h1);
      axi_wr(REG_CTRL, 32'h10);
      chk(link_i.conversion_ready_n, 1'h1);
      dev(OP_READ, ADDR_GAIN_SELECT, 8'h00, 1'h0);
      chk(rd_b, GAIN_SELECT_RST);
      dev(OP_WRITE, ADDR_GAIN_SELECT, g, 1'h0);
      dev(OP_RESET, 8'h00, 8'h00, 1'h0);
      dev(OP_READ, ADDR_GAIN_SELECT, 8'h00, 1'h0);
      chk(rd_b, GAIN_SELECT_RST);
      dev(OP_START, 8'h00, 8'h00, 1'h0);
      dev(OP_READ, ADDR_FIRST_STATUS, 8'h00, 1'h0);
      chk(rd_b[BUSY_BIT], 1'h1);
      axi_wr(REG_CTRL, 32'h14);
      dev(OP_WRITE, ADDR_CONV_CTRL, 8'h01, 1'h0);
      conv_done <= 1'h1;
      @(posedge aclk);
      conv_done <= 1'h0;
      seen = 1'h0;
      repeat (10)
      begin
         @(posedge aclk);
         seen = seen | conv_start;
      end
      chk(seen, 1'h1);
      axi_wr(REG_CTRL, 32'h10);
      dev(OP_WRITE, ADDR_GPIO_LEVEL, 8'h05, 1'h0);
      chk(gpio_o, 4'h5);
      dev(OP_READ, ADDR_GPIO_LEVEL, 8'h00, 1'h0);
      chk(rd_b, {4'h0, gpio_i});
      $display("test start and reset done");
      axi_wr(REG_CTRL, 32'h11);
      repeat (20) @(posedge aclk);
      chk(osc_halted, 1'h1);
      axi_wr(REG_CTRL, 32'h12);
      repeat (20) @(posedge aclk);
      chk(osc_external, 1'h1);
      axi_wr(REG_CTRL, 32'h10);
      repeat (20) @(posedge aclk);
      chk(osc_internal, 1'h1);
      $display("test clock source done");
      finish_test();
   end
endmodule : test_alarm_and_status_registers
